// ==== hw/pdd_pkg.sv ====
/*
  Package for the dither and debug-halt block: register indices, field
  positions, reset values, bus widths.
  Assumes a single 200 MHz clock domain and a word-addressed Avalon-MM bus.
*/
package pdd_pkg;
  localparam int unsigned ADDR_W = 6;
  // Printed offsets are not all multiples of four: byte address = 4 * index
  localparam logic [ADDR_W-1:0] IDX_DITHER     = 6'h19;
  localparam logic [ADDR_W-1:0] IDX_DEBUG      = 6'h1e;
  localparam logic [ADDR_W-1:0] IDX_CONTROL    = 6'h30;
  localparam logic [ADDR_W-1:0] IDX_INTSTATUS  = 6'h31;
  localparam logic [ADDR_W-1:0] IDX_INTMASK    = 6'h32;
  localparam logic [ADDR_W-1:0] IDX_STATE      = 6'h33;
  localparam int unsigned DITHER_LSB   = 0;
  localparam int unsigned DITHER_W     = 4;
  localparam int unsigned DBG_RUN_BIT  = 0;
  localparam int unsigned DBG_FAULT_BIT = 2;
  localparam int unsigned CTL_EN_BIT   = 0;
  localparam int unsigned CTL_SEL_BIT  = 1;
  localparam int unsigned CTL_UPD_BIT  = 2;
  localparam int unsigned IRQ_OVF_BIT  = 0;
  localparam int unsigned IRQ_FLT_BIT  = 1;
  localparam logic [7:0]  DITHER_RESET = 8'h00;
  localparam logic [7:0]  DEBUG_RESET  = 8'h00;
  localparam logic [11:0] PERIOD_RESET = 12'h00ff;
  localparam logic [11:0] ONTIME_RESET = 12'h0080;
  localparam logic [31:0] UNMAPPED_RD  = 32'h0000_0000;

  typedef enum logic [1:0] {
    PH_ON  = 2'b01,
    PH_OFF = 2'b10
  } pdd_phase_e;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic              read;
    logic              write;
    logic [31:0]       writedata;
    logic [3:0]        byteenable;
  } pdd_avreq_s;
endpackage

// ==== hw/pdd_top.sv ====
/*
  Dither accumulator and debug-halt control of a 12-bit waveform timer,
  with a simple on/off phase generator, registers and an interrupt.
  Assumes dbgHalt and trigger inputs come from other clock domains and
  that the bus master keeps requests stable while waitrequest is high.
*/
// Summary of operation
// - At each timer cycle end the active dither value is added to a 4-bit accumulator.
// - An accumulator overflow applies one adjustment step to the next timer cycle.
// - Dither bits 3:0 set the fraction, stretching on-time or off-time per dither select.
// - Written dither is buffered and copied to the active value only on an update.
// - With halt fault detect clear, a debug stop raises no fault.
// - With halt fault detect (bit 2) set and run-while-halted clear, a debug halt raises a fault and both trigger flags.
// - With run-while-halted clear, a debug halt stops the timer and ignores events.
// - With run-while-halted (bit 0) set, the timer keeps running during a debug halt.
module pdd_top
  import pdd_pkg::*;
#(
  parameter int unsigned CNT_W = 12
) (
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              dbgHalt,
  input  wire logic              eventIn,
  output logic                   waveOut,
  output logic                   faultOut,
  output logic                   trigAFlag,
  output logic                   trigBFlag,
  output logic                   cycleEnd,
  output logic                   irq
);
  pdd_avreq_s req;
  assign req = '{avs_address, avs_read, avs_write, avs_writedata, avs_byteenable};

  logic [7:0]       ditherBuf_reg;
  logic [3:0]       ditherAct_reg;
  logic [7:0]       debug_reg;
  logic [1:0]       control_reg;
  logic [1:0]       intStatus_reg;
  logic [1:0]       intMask_reg;
  logic [3:0]       acc_reg;
  logic             stretch_reg;
  logic             stretchUsed_reg;
  logic [CNT_W-1:0] cnt_reg;
  pdd_phase_e       phase_reg;
  logic             updPend_reg;
  logic             ack_reg;
  logic [1:0]       haltSync_reg;
  logic [1:0]       evSync_reg;
  logic             evPrev_reg;

  // Single-cycle answer: waitrequest drops one cycle after the request
  wire accStrobe = (req.read | req.write) & ~ack_reg;
  wire wrStb     = req.write & ~ack_reg;
  wire wrLane0   = wrStb & req.byteenable[0];
  wire wrDither  = wrLane0 & (req.address == IDX_DITHER);
  wire wrDebug   = wrLane0 & (req.address == IDX_DEBUG);
  wire wrControl = wrLane0 & (req.address == IDX_CONTROL);
  wire wrStatus  = wrLane0 & (req.address == IDX_INTSTATUS);
  wire wrMask    = wrLane0 & (req.address == IDX_INTMASK);

  wire halted    = haltSync_reg[1];
  wire runOk     = ~halted | debug_reg[DBG_RUN_BIT];
  wire timerRun  = control_reg[CTL_EN_BIT] & runOk;
  wire haltFault = halted & ~debug_reg[DBG_RUN_BIT] & debug_reg[DBG_FAULT_BIT];
  wire evEdge    = evSync_reg[1] & ~evPrev_reg & runOk;
  wire stretchOn = ~control_reg[CTL_SEL_BIT];

  // Phase lengths: one extra clock in the selected phase when stretching
  wire [CNT_W-1:0] onLen  = ONTIME_RESET[CNT_W-1:0];
  wire [CNT_W-1:0] offLen = PERIOD_RESET[CNT_W-1:0] - ONTIME_RESET[CNT_W-1:0];
  wire inStretchPh = stretch_reg & ~stretchUsed_reg &
                     ((phase_reg == PH_ON) == stretchOn);
  wire [CNT_W-1:0] phLen  = (phase_reg == PH_ON) ? onLen : offLen;
  wire phLast    = (cnt_reg == phLen - CNT_W'(1));
  wire extend    = phLast & inStretchPh;
  wire phDone    = timerRun & phLast & ~extend;
  wire cycDone   = phDone & (phase_reg == PH_OFF);
  wire [4:0] accSum = {1'b0, acc_reg} + {1'b0, ditherAct_reg};
  wire overflow  = cycDone & accSum[4];
  wire doUpdate  = cycDone & updPend_reg;
  wire [1:0] intEvents = {haltFault, overflow};

  wire [31:0] rdData =
      (req.address == IDX_DITHER)    ? {24'h00_0000, ditherBuf_reg} :
      (req.address == IDX_DEBUG)     ? {24'h00_0000, 5'h00, debug_reg[2], 1'b0, debug_reg[0]} :
      (req.address == IDX_CONTROL)   ? {29'h0000_0000, updPend_reg, control_reg[1:0]} :
      (req.address == IDX_INTSTATUS) ? {30'h0000_0000, intStatus_reg} :
      (req.address == IDX_INTMASK)   ? {30'h0000_0000, intMask_reg} :
      (req.address == IDX_STATE)     ? {27'h000_0000, stretch_reg, acc_reg} :
                                       UNMAPPED_RD;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ack_reg         <= 1'b0;
      avs_readdata    <= UNMAPPED_RD;
      avs_waitrequest <= 1'b1;
    end else begin
      ack_reg         <= accStrobe;
      avs_readdata    <= accStrobe ? rdData : avs_readdata;
      avs_waitrequest <= ~accStrobe;
    end
  end

  // Bus answers after exactly one wait cycle
  wait_ans_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    accStrobe |=> !avs_waitrequest)
    else $error("waitrequest not dropped after request");

  wait_one_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");

  rdata_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    !accStrobe |=> $stable(avs_readdata))
    else $error("read data changed between accesses");

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      haltSync_reg <= 2'b00;
      evSync_reg   <= 2'b00;
      evPrev_reg   <= 1'b0;
    end else begin
      haltSync_reg <= {haltSync_reg[0], dbgHalt};
      evSync_reg   <= {evSync_reg[0], eventIn};
      evPrev_reg   <= evSync_reg[1];
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ditherBuf_reg <= DITHER_RESET;
      debug_reg     <= DEBUG_RESET;
      control_reg   <= 2'b00;
      intMask_reg   <= 2'b00;
    end else begin
      if (wrDither) ditherBuf_reg <= {4'h0, req.writedata[DITHER_LSB +: DITHER_W]};
      if (wrDebug) debug_reg <= {5'h00, req.writedata[2], 1'b0, req.writedata[0]};
      if (wrControl) control_reg <= req.writedata[1:0];
      if (wrMask) intMask_reg <= req.writedata[1:0];
    end
  end

  buf_write_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    wrDither |=> ditherBuf_reg == {4'h0, $past(avs_writedata[3:0])})
    else $error("dither buffer not written");

  // Update request: set by software or trigger event, consumed at cycle end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      updPend_reg   <= 1'b0;
      ditherAct_reg <= DITHER_RESET[3:0];
    end else begin
      if (doUpdate) ditherAct_reg <= ditherBuf_reg[3:0];
      if ((wrControl & req.writedata[CTL_UPD_BIT]) | evEdge) updPend_reg <= 1'b1;
      else if (doUpdate) updPend_reg <= 1'b0;
    end
  end

  dither_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    ~doUpdate |=> $stable(ditherAct_reg))
    else $error("active dither changed without update");

  dither_load_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    doUpdate |=> ditherAct_reg == $past(ditherBuf_reg[3:0]))
    else $error("dither not loaded at update");

  pend_clear_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (doUpdate & ~evEdge & ~wrControl) |=> ~updPend_reg)
    else $error("update request not consumed");

  event_ignore_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (haltSync_reg[1] & ~debug_reg[0] & ~updPend_reg & ~wrControl) |=> ~updPend_reg)
    else $error("event taken while halted");

  // Set wins over write-one-to-clear
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      intStatus_reg <= 2'b00;
      irq           <= 1'b0;
    end else begin
      intStatus_reg <= (intStatus_reg & ~({2{wrStatus}} & req.writedata[1:0])) | intEvents;
      irq           <= |(intStatus_reg & intMask_reg);
    end
  end

  irq_on_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (|(intStatus_reg & intMask_reg)) |=> irq)
    else $error("irq low with unmasked status");

  irq_off_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (~|(intStatus_reg & intMask_reg)) |=> !irq)
    else $error("irq high without unmasked status");

  ovf_flag_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    overflow |=> intStatus_reg[IRQ_OVF_BIT])
    else $error("overflow status not set");

  fault_flag_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    haltFault |=> intStatus_reg[IRQ_FLT_BIT])
    else $error("fault status not set");

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg         <= '0;
      phase_reg       <= PH_ON;
      acc_reg         <= 4'h0;
      stretch_reg     <= 1'b0;
      stretchUsed_reg <= 1'b0;
    end else if (timerRun) begin
      if (extend) begin
        stretchUsed_reg <= 1'b1;
      end else if (phLast) begin
        cnt_reg   <= '0;
        phase_reg <= (phase_reg == PH_ON) ? PH_OFF : PH_ON;
        if (phase_reg == PH_OFF) begin
          acc_reg         <= accSum[3:0];
          stretch_reg     <= accSum[4];
          stretchUsed_reg <= 1'b0;
        end
      end else begin
        cnt_reg <= cnt_reg + CNT_W'(1);
      end
    end
  end

  halt_stop_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (haltSync_reg[1] & ~debug_reg[0]) |=> $stable(cnt_reg) && $stable(acc_reg))
    else $error("timer moved while halted");

  halt_run_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (haltSync_reg[1] & debug_reg[0] & control_reg[0] & ~phLast) |=>
      cnt_reg == $past(cnt_reg) + CNT_W'(1))
    else $error("timer stopped with run while halted");

  acc_add_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    cycDone |=> acc_reg == 4'($past(acc_reg) + $past(ditherAct_reg)))
    else $error("accumulator not advanced");

  ovf_step_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    cycDone |=> stretch_reg == $past(accSum[4]))
    else $error("overflow step missing");

  stretch_one_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (extend & timerRun) |=> ~extend)
    else $error("stretch longer than one clock");

  ext_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (extend & timerRun) |=> stretchUsed_reg && $stable(cnt_reg) && $stable(phase_reg))
    else $error("stretch clock not held");

  ext_phase_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    extend |-> ((phase_reg == PH_ON) == ~control_reg[CTL_SEL_BIT]))
    else $error("stretch in wrong phase");

  // Fault held as long as the halt condition lasts
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      waveOut   <= 1'b0;
      faultOut  <= 1'b0;
      trigAFlag <= 1'b0;
      trigBFlag <= 1'b0;
      cycleEnd  <= 1'b0;
    end else begin
      waveOut   <= timerRun & (phase_reg == PH_ON);
      faultOut  <= haltFault;
      trigAFlag <= haltFault | (trigAFlag & ~wrStatus);
      trigBFlag <= haltFault | (trigBFlag & ~wrStatus);
      cycleEnd  <= cycDone;
    end
  end

  halt_fault_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (haltSync_reg[1] & ~debug_reg[0] & debug_reg[2]) |=> faultOut & trigAFlag & trigBFlag)
    else $error("halt fault not raised");

  no_fault_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    ~debug_reg[2] |=> ~faultOut)
    else $error("fault raised with detect off");

  fault_drop_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    ~haltFault |=> ~faultOut)
    else $error("fault held without halt condition");

  run_nofault_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    debug_reg[DBG_RUN_BIT] |=> ~faultOut)
    else $error("fault raised while running in halt");

  trig_sticky_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (trigAFlag & trigBFlag & ~wrStatus) |=> trigAFlag & trigBFlag)
    else $error("trigger flags lost without clear");

  wave_stop_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (haltSync_reg[1] & ~debug_reg[DBG_RUN_BIT]) |=> ~waveOut)
    else $error("waveform active while halted");

  wave_on_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (timerRun & (phase_reg == PH_ON)) |=> waveOut)
    else $error("waveform low in on phase");

  cycle_pulse_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    cycleEnd |=> ~cycleEnd)
    else $error("cycle end pulse longer than one clock");
endmodule

// ==== tb/testbench.sv ====
/*
  Self-checking bench for pdd_top: registers, dither buffering, stretch,
  interrupt and debug halt.
  Assumes a fixed 255-clock period with a 128-clock on-phase.
*/
module testbench
  import pdd_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] ALL = 32'hffff_ffff;
  logic              sys_clk = 1'b0;
  logic              rstn    = 1'b0;
  logic              rd      = 1'b0;
  logic              wr      = 1'b0;
  logic              dbgHalt = 1'b0;
  logic              eventIn = 1'b0;
  logic [ADDR_W-1:0] addr    = '0;
  logic [31:0]       wdata   = '0;
  logic [31:0]       rdata, v, a0;
  logic              waitreq, waveOut, faultOut, trigA, trigB, cycleEnd, irq;
  int                numErrors = 0;
  int                samplesChecked = 0;
  int                len, on, n;

  always #2.5 sys_clk = ~sys_clk;

  pdd_top dut (.sys_clk(sys_clk), .rstn(rstn), .avs_address(addr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(4'h1), .avs_readdata(rdata),
    .avs_waitrequest(waitreq), .dbgHalt(dbgHalt), .eventIn(eventIn), .waveOut(waveOut),
    .faultOut(faultOut), .trigAFlag(trigA), .trigBFlag(trigB), .cycleEnd(cycleEnd),
    .irq(irq));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samplesChecked, numErrors);
    if (numErrors == 0 && samplesChecked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samplesChecked++;
    if (got !== exp) begin
      numErrors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic timeout(input string what);
    numErrors++;
    $display("mismatch %s expected done seen timeout", what);
    complete_run();
  endtask

  // Waitrequest and read data taken at the rising edge, as the slave sees them
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int k;
    @(posedge sys_clk);
    addr  <= a;
    wr    <= w;
    rd    <= !w;
    wdata <= d;
    for (k = 0; k < 20; k++) begin
      @(posedge sys_clk);
      if (waitreq === 1'b0) break;
    end
    if (k == 20) timeout("waitrequest");
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] m,
                     input logic [31:0] exp, input string what);
    bus(1'b0, a, '0, v);
    check(what, exp, v & m);
  endtask

  task automatic wait_end(input int lim);
    int k;
    for (k = 0; k < lim; k++) begin
      @(negedge sys_clk);
      if (cycleEnd === 1'b1) break;
    end
    if (k == lim) timeout("cycleEnd");
    @(posedge sys_clk);
  endtask

  task automatic measure();
    len = 0;
    on  = 0;
    do begin
      @(negedge sys_clk);
      len++;
      on += int'(waveOut === 1'b1);
    end while (cycleEnd !== 1'b1 && len < 600);
    if (cycleEnd !== 1'b1) timeout("measure");
    @(posedge sys_clk);
  endtask

  task automatic t_regs();
    rdc(IDX_DITHER, ALL, 32'(DITHER_RESET), "dither reset");
    rdc(IDX_DEBUG, ALL, 32'(DEBUG_RESET), "debug reset");
    bus(1'b1, IDX_DITHER, 32'h0000_00ff, v);
    rdc(IDX_DITHER, ALL, 32'h0000_000f, "dither field");
    bus(1'b1, IDX_DEBUG, 32'h0000_00ff, v);
    rdc(IDX_DEBUG, ALL, 32'h0000_0005, "debug fields");
    bus(1'b1, 6'h05, ALL, v);
    rdc(6'h05, ALL, UNMAPPED_RD, "unmapped");
    bus(1'b1, IDX_DEBUG, '0, v);
    bus(1'b1, IDX_DITHER, 32'h0000_0008, v);
    $display("test regs done");
  endtask

  // Dither 8 was written but not yet updated: accumulator must not move
  task automatic t_buffer();
    bus(1'b1, IDX_CONTROL, 32'h0000_0001, v);
    wait_end(600);
    wait_end(600);
    rdc(IDX_STATE, 32'h0000_000f, '0, "acc before update");
    bus(1'b1, IDX_CONTROL, 32'h0000_0005, v);
    wait_end(600);
    wait_end(600);
    bus(1'b0, IDX_STATE, '0, a0);
    wait_end(600);
    rdc(IDX_STATE, 32'h0000_000f, (a0 + 8) & 32'h0000_000f, "acc step");
    $display("test buffer done");
  endtask

  // Dither 8 overflows every second cycle: one stretch per pair
  task automatic t_stretch(input logic sel);
    int s;
    int o;
    bus(1'b1, IDX_CONTROL, sel ? 32'h0000_0003 : 32'h0000_0001, v);
    wait_end(600);
    measure();
    s = len;
    o = on;
    measure();
    check("two periods", 32'd511, 32'(s + len));
    check("two on-times", 32'd257 - 32'(sel), 32'(o + on));
    $display("test stretch %0d done", sel);
  endtask

  task automatic t_irq();
    bus(1'b1, IDX_INTMASK, 32'h0000_0001, v);
    wait_end(600);
    wait_end(600);
    repeat (2) @(negedge sys_clk);
    check("irq", 32'h1, 32'(irq));
    rdc(IDX_INTSTATUS, 32'h0000_0001, 32'h0000_0001, "overflow status");
    bus(1'b1, IDX_INTMASK, '0, v);
    bus(1'b1, IDX_INTSTATUS, 32'h0000_0003, v);
    repeat (2) @(negedge sys_clk);
    check("irq masked", 32'h0, 32'(irq));
    $display("test irq done");
  endtask

  task automatic t_halt();
    bus(1'b1, IDX_DEBUG, '0, v);
    dbgHalt <= 1'b1;
    repeat (10) @(posedge sys_clk);
    for (n = 0; n < 600; n++) begin
      @(negedge sys_clk);
      if (cycleEnd === 1'b1) break;
    end
    check("halted cycle ends", 32'd600, 32'(n));
    check("no fault", 32'h0, 32'(faultOut));
    @(posedge sys_clk);
    eventIn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    eventIn <= 1'b0;
    rdc(IDX_CONTROL, 32'h0000_0004, '0, "event ignored");
    bus(1'b1, IDX_DEBUG, 32'h0000_0004, v);
    repeat (6) @(negedge sys_clk);
    check("fault", 32'h1, 32'(faultOut));
    check("trig flags", 32'h3, 32'({trigA, trigB}));
    rdc(IDX_INTSTATUS, 32'h0000_0002, 32'h0000_0002, "fault status");
    bus(1'b1, IDX_DEBUG, 32'h0000_0005, v);
    wait_end(600);
    dbgHalt <= 1'b0;
    $display("test halt done");
  endtask

  initial begin
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    t_regs();
    t_buffer();
    t_stretch(1'b0);
    t_stretch(1'b1);
    t_irq();
    t_halt();
    complete_run();
  end
endmodule
